/* pkg/epd_pkg.sv */
// constants shared by the encoder preset, direction and capture block
package epd_pkg;
  // =========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_CFG    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_LATCH1 = 8'h14;
  localparam logic [7:0] OFS_LATCH2 = 8'h18;
  // =========================================================
  // command bit positions
  localparam int CMD_SET_SW    = 0;
  localparam int CMD_SET_IDX   = 1;
  localparam int CMD_SET_RISE  = 2;
  localparam int CMD_SET_FALL  = 3;
  localparam int CMD_CAP_IDX   = 4;
  localparam int CMD_CAP_RISE  = 5;
  localparam int CMD_CAP_FALL  = 6;
  localparam int CMD_CAP2_RISE = 7;
  localparam int CMD_CAP2_FALL = 8;
  localparam int CMD_W         = 9;
  // =========================================================
  // configuration fields
  localparam int CFG_HYST_W = 16;
  localparam int CFG_INV    = 16;
  localparam int CFG_CONT1  = 17;
  localparam int CFG_CONT2  = 18;
  // =========================================================
  // status bit positions
  localparam int ST_DONE   = 0;
  localparam int ST_CVALID = 1;
  localparam int ST_EVALID = 2;
  localparam int ST_E2VAL  = 3;
  localparam int ST_DIR    = 4;
  // =========================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [8:0]  RST_CMD  = 9'h000;
  // =========================================================
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;
  // =========================================================
  // arbitration owners
  typedef enum logic [2:0] {PO_NONE, PO_SW, PO_IDX, PO_RISE, PO_FALL} epd_powner_t;
  typedef enum logic [1:0] {CO_NONE, CO_IDX, CO_EXT} epd_cowner_t;
endpackage : epd_pkg

/* hdl/epd_top.sv */
// encoder preset, direction detection and capture arbitration with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
module epd_top (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        COUNT_UP,
  input  wire logic        COUNT_DN,
  input  wire logic        CYCLE_STROBE,
  input  wire logic        ZERO_PULSE,
  input  wire logic        LATCH_EXT,
  input  wire logic        GATE_LATCH,
  output logic             DIR_FLAG
);
  import epd_pkg::*;

  logic [CMD_W-1:0] cmd_q, cmd_prev_q;
  logic [31:0]      preset_q, cfg_q, cnt_q, prev_q, latch1_q, latch2_q;
  logic             wr_q;
  logic [7:0]       wa_q;
  logic [31:0]      rdata_q;
  logic [2:0]       zs_q, ls_q, gs_q;
  logic             z_rise, l_rise, l_fall, g_rise, g_fall;
  epd_powner_t      pown_q;
  epd_cowner_t      cown_q;
  logic             done_q, pfire, cvalid_q, evalid_q, e2valid_q;
  logic             cap1, cap2;
  logic             dir_q, first_q, wrap_q, wrap_now;
  logic [31:0]      diff;
  logic             inv;
  logic [CFG_HYST_W-1:0] hyst, run_q, run_n;
  logic             last_q, seen_q, chg_q, hit_q, chg_n, hit_n, pulse, pdir;
  logic [CMD_W-1:0] cmd_rise;

  // =========================================================
  // AHB-Lite slave, zero wait states
  logic acc;
  assign acc = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
  assign HREADYOUT = 1'b1;
  assign HRESP     = HRESP_OKAY;
  assign HRDATA    = rdata_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc && HWRITE;
      wa_q <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_q <= RST_WORD;
    end else if (acc && !HWRITE) begin
      if (HADDR[7:0] == OFS_CMD) begin
        rdata_q <= {23'h00_0000, cmd_q};
      end else if (HADDR[7:0] == OFS_PRESET) begin
        rdata_q <= preset_q;
      end else if (HADDR[7:0] == OFS_CFG) begin
        rdata_q <= cfg_q;
      end else if (HADDR[7:0] == OFS_STATUS) begin
        rdata_q <= {27'h000_0000, dir_q, e2valid_q, evalid_q, cvalid_q, done_q};
      end else if (HADDR[7:0] == OFS_COUNT) begin
        rdata_q <= cnt_q;
      end else if (HADDR[7:0] == OFS_LATCH1) begin
        rdata_q <= latch1_q;
      end else if (HADDR[7:0] == OFS_LATCH2) begin
        rdata_q <= latch2_q;
      end else begin
        rdata_q <= RST_WORD;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_q    <= RST_CMD;
      preset_q <= RST_WORD;
      cfg_q    <= RST_WORD;
    end else if (wr_q) begin
      if (wa_q == OFS_CMD) begin
        cmd_q <= HWDATA[CMD_W-1:0];
      end else if (wa_q == OFS_PRESET) begin
        preset_q <= HWDATA;
      end else if (wa_q == OFS_CFG) begin
        cfg_q <= {13'h0000, HWDATA[18:0]};
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_prev_q <= RST_CMD;
    end else begin
      cmd_prev_q <= cmd_q;
    end
  end
  assign cmd_rise = cmd_q & ~cmd_prev_q;
  assign hyst = cfg_q[CFG_HYST_W-1:0];
  assign inv  = cfg_q[CFG_INV];

  // =========================================================
  // pin synchronisers; edges only from stages two and three
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      zs_q <= 3'h0;
      ls_q <= 3'h0;
      gs_q <= 3'h0;
    end else begin
      zs_q <= {zs_q[1:0], ZERO_PULSE};
      ls_q <= {ls_q[1:0], LATCH_EXT};
      gs_q <= {gs_q[1:0], GATE_LATCH};
    end
  end
  assign z_rise = zs_q[1] && !zs_q[2];
  assign l_rise = ls_q[1] && !ls_q[2];
  assign l_fall = !ls_q[1] && ls_q[2];
  assign g_rise = gs_q[1] && !gs_q[2];
  assign g_fall = !gs_q[1] && gs_q[2];

  // =========================================================
  // preset arbitration
  logic pre_any;
  assign pre_any = |cmd_q[CMD_SET_FALL:CMD_SET_SW];

  always_comb begin
    case (pown_q)
      PO_SW:   pfire = cmd_q[CMD_SET_SW] && !done_q;
      PO_IDX:  pfire = cmd_q[CMD_SET_IDX] && !done_q && z_rise;
      PO_RISE: pfire = cmd_q[CMD_SET_RISE] && !done_q && l_rise;
      PO_FALL: pfire = cmd_q[CMD_SET_FALL] && !done_q && l_fall;
      default: pfire = 1'b0;
    endcase
  end

  // later commands stay armed but never take ownership
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pown_q <= PO_NONE;
    end else if (!pre_any) begin
      pown_q <= PO_NONE;
    end else if (pown_q == PO_NONE && !done_q) begin
      if (cmd_rise[CMD_SET_SW]) begin
        pown_q <= PO_SW;
      end else if (cmd_rise[CMD_SET_IDX]) begin
        pown_q <= PO_IDX;
      end else if (cmd_rise[CMD_SET_RISE]) begin
        pown_q <= PO_RISE;
      end else if (cmd_rise[CMD_SET_FALL]) begin
        pown_q <= PO_FALL;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      done_q <= 1'b0;
    end else if (pfire) begin
      done_q <= 1'b1;
    end else if (!pre_any) begin
      done_q <= 1'b0;
    end
  end

  // =========================================================
  // counter, preset load and wrap detection
  assign pulse    = COUNT_UP ^ COUNT_DN;
  assign wrap_now = !pfire && pulse &&
                    ((COUNT_UP && cnt_q == 32'hFFFF_FFFF) || (COUNT_DN && cnt_q == 32'h0000_0000));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_q <= RST_WORD;
    end else if (pfire) begin
      cnt_q <= preset_q;
    end else if (pulse && COUNT_UP) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end else if (pulse) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wrap_q <= 1'b0;
    end else if (wrap_now) begin
      wrap_q <= 1'b1;
    end else if (CYCLE_STROBE) begin
      wrap_q <= 1'b0;
    end
  end

  // =========================================================
  // direction and reversal evaluation
  // in sign mode a wrap in the cycle holds the direction; preset jumps stay visible
  assign diff = cnt_q - prev_q;
  assign pdir = COUNT_DN ^ inv;

  always_comb begin
    run_n = run_q;
    chg_n = chg_q;
    hit_n = hit_q;
    if (pulse) begin
      if (seen_q && pdir != last_q) begin
        run_n = {{(CFG_HYST_W-1){1'b0}}, 1'b1};
        chg_n = 1'b1;
      end else if (run_q != {CFG_HYST_W{1'b1}}) begin
        run_n = run_q + {{(CFG_HYST_W-1){1'b0}}, 1'b1};
      end
      hit_n = hit_q || (chg_n && run_n > hyst);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      run_q  <= '0;
      chg_q  <= 1'b0;
      hit_q  <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 1'b0;
    end else if (CYCLE_STROBE) begin
      run_q  <= '0;
      chg_q  <= 1'b0;
      hit_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      run_q <= run_n;
      chg_q <= chg_n;
      hit_q <= hit_n;
      if (pulse) begin
        seen_q <= 1'b1;
        last_q <= pdir;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dir_q   <= 1'b0;
      first_q <= 1'b1;
      prev_q  <= RST_WORD;
    end else if (CYCLE_STROBE) begin
      prev_q  <= cnt_q;
      first_q <= 1'b0;
      if (first_q) begin
        dir_q <= 1'b0;
      end else if (hyst != '0) begin
        dir_q <= hit_n;
      end else if (!wrap_q && !wrap_now && diff != 32'h0000_0000) begin
        dir_q <= diff[31] ^ inv;
      end
    end
  end
  assign DIR_FLAG = dir_q;

  // =========================================================
  // primary capture arbitration
  logic cap_any;
  assign cap_any = |cmd_q[CMD_CAP_FALL:CMD_CAP_IDX];

  always_comb begin
    case (cown_q)
      CO_IDX:  cap1 = cmd_q[CMD_CAP_IDX] && !cvalid_q && z_rise;
      CO_EXT:  cap1 = (!evalid_q || cfg_q[CFG_CONT1]) &&
                      ((cmd_q[CMD_CAP_RISE] && l_rise) || (cmd_q[CMD_CAP_FALL] && l_fall));
      default: cap1 = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cown_q <= CO_NONE;
    end else if (!cap_any) begin
      cown_q <= CO_NONE;
    end else if (cown_q == CO_NONE && !cvalid_q && !evalid_q) begin
      if (cmd_rise[CMD_CAP_IDX]) begin
        cown_q <= CO_IDX;
      end else if (cmd_rise[CMD_CAP_RISE] || cmd_rise[CMD_CAP_FALL]) begin
        cown_q <= CO_EXT;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cvalid_q <= 1'b0;
      evalid_q <= 1'b0;
      latch1_q <= RST_WORD;
    end else if (cap1) begin
      latch1_q <= cnt_q;
      if (cown_q == CO_IDX) begin
        cvalid_q <= 1'b1;
      end else begin
        evalid_q <= 1'b1;
      end
    end else if (!cap_any) begin
      cvalid_q <= 1'b0;
      evalid_q <= 1'b0;
    end
  end

  // =========================================================
  // second capture source on the gate input
  logic cap2_any;
  assign cap2_any = cmd_q[CMD_CAP2_RISE] || cmd_q[CMD_CAP2_FALL];
  assign cap2 = (!e2valid_q || cfg_q[CFG_CONT2]) &&
                ((cmd_q[CMD_CAP2_RISE] && g_rise) || (cmd_q[CMD_CAP2_FALL] && g_fall));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      e2valid_q <= 1'b0;
      latch2_q  <= RST_WORD;
    end else if (cap2) begin
      latch2_q  <= cnt_q;
      e2valid_q <= 1'b1;
    end else if (!cap2_any) begin
      e2valid_q <= 1'b0;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sw_preset_done_a: assert property (pown_q == PO_SW && cmd_q[CMD_SET_SW] && !done_q
    |=> done_q && cnt_q == $past(preset_q)) else $error("sw preset not applied");
  preset_load_a: assert property (pfire |=> cnt_q == $past(preset_q) ##1 done_q || !pre_any)
    else $error("preset value not loaded");
  done_clear_a: assert property (!pre_any |=> !done_q && pown_q == PO_NONE)
    else $error("done flag not released");
  owner_hold_a: assert property (pown_q != PO_NONE && pre_any |=> pown_q == $past(pown_q))
    else $error("preset owner changed while armed");
  first_dir_a: assert property (first_q && CYCLE_STROBE |=> !dir_q && !first_q)
    else $error("first cycle not positive");
  dir_hold_a: assert property (CYCLE_STROBE && !first_q && hyst == '0 && (diff == '0 || wrap_q)
    |=> $stable(dir_q)) else $error("direction moved without cause");
  dir_sign_a: assert property (CYCLE_STROBE && !first_q && hyst == '0 && !wrap_q && !wrap_now
    && diff != '0 |=> dir_q == ($past(diff[31]) ^ $past(inv))) else $error("direction sign wrong");
  rev_flag_a: assert property (CYCLE_STROBE && !first_q && hyst != '0
    |=> dir_q == $past(hit_n) && !hit_q && run_q == '0) else $error("reversal flag wrong");
  cap_once_a: assert property (evalid_q && !cfg_q[CFG_CONT1] && cap_any |=> $stable(latch1_q))
    else $error("single capture overwritten");
  cap2_once_a: assert property (e2valid_q && !cfg_q[CFG_CONT2] && cap2_any |=> $stable(latch2_q))
    else $error("second capture overwritten");

  sw_preset_c: cover property (pfire && pown_q == PO_SW);
  idx_preset_c: cover property (pfire && pown_q == PO_IDX);
  ext_cap_c: cover property (cap1 && cown_q == CO_EXT);
  rev_seen_c: cover property (CYCLE_STROBE && hyst != '0 && hit_n);
endmodule : epd_top
`default_nettype wire

/* verification/epd_pins.sv */
// encoder side model: count pulses, control cycle strobe and the three pins
`timescale 1ns/1ns
`default_nettype none
module epd_pins (
  input  wire logic CLOCK,
  output var logic  COUNT_UP,
  output var logic  COUNT_DN,
  output var logic  CYCLE_STROBE,
  output var logic  ZERO_PULSE,
  output var logic  LATCH_EXT,
  output var logic  GATE_LATCH
);
  logic [2:0] pin_q;
  assign ZERO_PULSE = pin_q[0];
  assign LATCH_EXT  = pin_q[1];
  assign GATE_LATCH = pin_q[2];
  initial begin
    COUNT_UP     = 1'b0;
    COUNT_DN     = 1'b0;
    CYCLE_STROBE = 1'b0;
    pin_q        = 3'h0;
  end
  // =========================================================
  // one pulse per two clocks, each one clock high, so each pulse is a single increment or decrement
  task automatic cnt(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      @(posedge CLOCK);
      COUNT_UP <= up;
      COUNT_DN <= !up;
      @(posedge CLOCK);
      COUNT_UP <= 1'b0;
      COUNT_DN <= 1'b0;
    end
  endtask
  task automatic strobe();
    @(posedge CLOCK);
    CYCLE_STROBE <= 1'b1;
    @(posedge CLOCK);
    CYCLE_STROBE <= 1'b0;
    repeat (3) @(posedge CLOCK);
  endtask
  // pins act three clocks late behind the synchronisers, so wait past that
  task automatic pin(input int i, input bit v);
    @(posedge CLOCK);
    pin_q[i] <= v;
    repeat (6) @(posedge CLOCK);
  endtask
endmodule // epd_pins
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the preset, direction and capture block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import epd_pkg::*;
  logic        clk = 1'b0;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        rd_ph;
  logic        c_up, c_dn, c_stb, z_p, l_e, g_l;
  logic        dflag, hresp;
  logic [31:0] cur;
  logic [31:0] p;
  logic [63:0] e;
  logic [63:0] q[$];
  int          err_total = 0;
  int          n_compared = 0;
  always #2 clk = ~clk;
  epd_top uut (.CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .COUNT_UP(c_up), .COUNT_DN(c_dn), .CYCLE_STROBE(c_stb), .ZERO_PULSE(z_p), .LATCH_EXT(l_e),
    .GATE_LATCH(g_l), .DIR_FLAG(dflag));
  epd_pins far (.CLOCK(clk), .COUNT_UP(c_up), .COUNT_DN(c_dn), .CYCLE_STROBE(c_stb), .ZERO_PULSE(z_p),
    .LATCH_EXT(l_e), .GATE_LATCH(g_l));
  // =========================================================
  // checking
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (rd_ph === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      cmp(hrdata, e[31:0], e[63:32]);
      cmp_flag(hresp, HRESP_OKAY);
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // =========================================================
  // bus master: no cycle count assumed, waits on ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    rd_ph  <= !w;
    if (!w) q.push_back({m, d});
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    bus(1'b0, a, x, m);
  endtask
  task automatic mv(input int n, input bit up);
    far.cnt(n, up);
    cur = up ? cur + n : cur - n;
  endtask
  task automatic dir(input bit x);
    far.strobe();
    cmp_flag(dflag, x);
    rd(OFS_STATUS, x ? 32'h0000_0010 : 32'h0000_0000, 32'h0000_0010);
  endtask
  task automatic zero();
    far.pin(0, 1'b1);
    far.pin(0, 1'b0);
  endtask
  initial begin
    #40000;
    err_total++;
    give_verdict();
  end
  // =========================================================
  // main sequence
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0000_0000; rd_ph = 1'b0;
    void'($urandom(83114));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS, RST_WORD, '1);
    rd(8'h1C, 32'h0000_0000, '1);
    wr(OFS_CFG, 32'hFFFF_FFFF);
    rd(OFS_CFG, 32'h0007_FFFF, '1);
    wr(OFS_CFG, 32'h0000_0000);
    p = 32'h1000_0000 | ($urandom & 32'h0FFF_FFFF);
    wr(OFS_PRESET, p);
    wr(OFS_CMD, 32'h0000_0001);
    cur = p;
    rd(OFS_COUNT, cur, '1);
    rd(OFS_STATUS, 32'h0000_0001, '1);
    wr(OFS_PRESET, p + 5);
    wr(OFS_CMD, 32'h0000_0003);
    zero();
    rd(OFS_COUNT, cur, '1);
    wr(OFS_CMD, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0000, '1);
    for (int k = 1; k < 4; k++) begin
      wr(OFS_PRESET, p + k * 16);
      wr(OFS_CMD, 32'h0000_0001 << k);
      if (k == 1) zero();
      else far.pin(1, k == 2);
      cur = p + k * 16;
      rd(OFS_COUNT, cur, '1);
      rd(OFS_STATUS, 32'h0000_0001, '1);
      wr(OFS_CMD, 32'h0000_0000);
      rd(OFS_STATUS, 32'h0000_0000, '1);
    end
    dir(1'b0);
    mv(3, 1'b0);
    dir(1'b1);
    dir(1'b1);
    wr(OFS_PRESET, cur + 32'h0000_0100);
    wr(OFS_CMD, 32'h0000_0002);
    zero();
    cur = cur + 32'h0000_0100;
    dir(1'b0);
    wr(OFS_CMD, 32'h0000_0000);
    wr(OFS_PRESET, cur - 100);
    wr(OFS_CMD, 32'h0000_0002);
    zero();
    cur = cur - 100;
    dir(1'b1);
    wr(OFS_CMD, 32'h0000_0000);
    mv(2, 1'b1);
    dir(1'b0);
    wr(OFS_CFG, 32'h0001_0000);
    mv(2, 1'b1);
    dir(1'b1);
    wr(OFS_CFG, 32'h0000_0002);
    dir(1'b0);
    mv(1, 1'b1);
    mv(3, 1'b0);
    dir(1'b1);
    dir(1'b0);
    mv(1, 1'b1);
    mv(2, 1'b0);
    dir(1'b0);
    mv(3, 1'b1);
    mv(3, 1'b0);
    mv(3, 1'b1);
    dir(1'b1);
    wr(OFS_CMD, 32'h0000_0030);
    zero();
    rd(OFS_LATCH1, cur, '1);
    mv(1, 1'b1);
    far.pin(1, 1'b1);
    rd(OFS_LATCH1, cur - 1, '1);
    rd(OFS_STATUS, 32'h0000_0002, 32'h0000_000E);
    wr(OFS_CMD, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_000E);
    wr(OFS_CFG, 32'h0004_0000);
    wr(OFS_CMD, 32'h0000_0080);
    far.pin(2, 1'b1);
    rd(OFS_LATCH2, cur, '1);
    mv(1, 1'b1);
    far.pin(2, 1'b0);
    mv(1, 1'b1);
    far.pin(2, 1'b1);
    rd(OFS_LATCH2, cur, '1);
    rd(OFS_STATUS, 32'h0000_0008, 32'h0000_000E);
    wr(OFS_CMD, 32'h0000_0000);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
